/* bench/button_model.sv */
// model of a push button or logic driver on one active-low input
// assumes the bench asks for presses in step with clk
`timescale 1ns/1ns
`default_nettype none

module button_model #(
    parameter int GAP = 2500
) (
    input wire logic clk,
    input wire logic press,
    output logic pin_n
);
    int gap_cnt = 0;

    // pull-up keeps the line high unless pressed
    always @(posedge clk) begin
        pin_n <= !(press && gap_cnt == 0);
        // a new press waits out the gap after a release
        if (!pin_n && !press) gap_cnt <= GAP;
        else if (gap_cnt > 0) gap_cnt <= gap_cnt - 1;
    end
endmodule : button_model

`default_nettype wire

/* bench/tap_counter_test.sv */
// self-checking bench for the push-button tap counter
// assumes button models on the three inputs and a 4-clock tick
`timescale 1ns/1ns
`default_nettype none
`include "tap_counter_map.svh"

module tap_counter_test;
    localparam int TK = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic up = 1'b0, dn = 1'b0, sv = 1'b0, supply_low = 1'b0, busy = 1'b0;
    logic up_n, dn_n, sv_n, nvm_write;
    logic [`POS_W-1:0] nvm_rdata = 5'h00, nvm_wdata, wiper_pos, prev, exp_pos;
    logic [`TAPS-1:0] tap_select;
    logic [31:0] pos_q[$], save_q[$];
    logic [31:0] seed = 32'hc860671e;
    int bad_count = 0, comparisons = 0;
    time t_last = 0, t_press = 0, dt, since;

    always #10 clk = ~clk;

    // gap of 4 clocks, one scaled tick, not the 50 us default scaled with the tick
    button_model #(.GAP(4)) i_button_up (.clk(clk), .press(up), .pin_n(up_n));
    button_model #(.GAP(4)) i_button_dn (.clk(clk), .press(dn), .pin_n(dn_n));
    button_model #(.GAP(4)) i_button_sv (.clk(clk), .press(sv), .pin_n(sv_n));

    tap_counter #(.TICK_CYCLES(16'h0004)) i_tap_counter (.clk(clk), .rst(rst),
        .step_up_n(up_n), .step_down_n(dn_n), .save_enable_n(sv_n),
        .supply_low(supply_low), .nvm_rdata(nvm_rdata), .nvm_write(nvm_write),
        .nvm_wdata(nvm_wdata), .wiper_pos(wiper_pos), .tap_select(tap_select));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk);
    endtask : ticks

    task automatic note(input logic go_up);
        logic [`POS_W-1:0] nx;
        nx = go_up ? (exp_pos == `POS_TOP ? exp_pos : exp_pos + 5'h01)
                   : (exp_pos == `POS_BOTTOM ? exp_pos : exp_pos - 5'h01);
        if (nx != exp_pos) pos_q.push_back({27'h0, nx});
        exp_pos = nx;
    endtask : note

    task automatic hold(input logic u, input logic d, input int n);
        t_press = $time;
        busy = 1'b1;
        up <= u;
        dn <= d;
        ticks(n);
        up <= 1'b0;
        dn <= 1'b0;
        ticks(50);
        busy = 1'b0;
        check(pos_q.size(), 0);
    endtask : hold

    task automatic do_reset(input logic strap_low);
        seed = xs(seed);
        rst <= 1'b1;
        sv <= strap_low;
        nvm_rdata <= seed[4:0] | 5'h01;
        repeat (6) @(posedge clk);
        exp_pos = seed[4:0] | 5'h01;
        pos_q.push_back({27'h0, exp_pos});
        rst <= 1'b0;
        ticks(50);
        check(pos_q.size(), 0);
    endtask : do_reset

    task automatic pulse_supply;
        supply_low <= 1'b1;
        ticks(2);
        supply_low <= 1'b0;
        ticks(2);
    endtask : pulse_supply

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // output watcher: pops the oldest note
    // ----------------------------------------
    always @(negedge clk) begin
        if (rst) begin
            prev = wiper_pos;
        end else if (wiper_pos !== prev) begin
            prev = wiper_pos;
            check(wiper_pos, pos_q.size() ? pos_q.pop_front() : 32'hffffffff);
            check(tap_select, 32'h1 << wiper_pos);
            dt = $time - t_last;
            since = $time - t_press;
            // times in ns, one tick is 80 ns
            if (busy && t_last < t_press)
                check(since >= 3200 && since <= 3560, 1);
            else if (busy && since < 80000)
                check(dt >= 8000 && dt <= 30000, 1);
            else if (busy && since > 88000)
                check(dt >= 2000 && dt <= 7200, 1);
            t_last = $time;
        end
        if (!rst && nvm_write === 1'b1)
            check(nvm_wdata, save_q.size() ? save_q.pop_front() : 32'hffffffff);
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b0);
        seed = xs(seed);
        hold(1'b1, 1'b0, int'(seed % 32'd38) + 1);
        note(1'b1);
        hold(1'b1, 1'b0, 60);
        for (int i = 0; i < 32; i++) note(1'b0);
        hold(1'b0, 1'b1, 2600);
        for (int i = 0; i < 32; i++) note(1'b1);
        hold(1'b1, 1'b0, 2600);
        note(1'b0);
        hold(1'b0, 1'b1, 120);
        hold(1'b1, 1'b1, 120);
        sv <= 1'b1;
        ticks(60);
        hold(1'b1, 1'b0, 120);
        save_q.push_back({27'h0, exp_pos});
        pulse_supply();
        save_q.push_back({27'h0, exp_pos});
        sv <= 1'b0;
        ticks(60);
        check(save_q.size(), 0);
        note(1'b1);
        hold(1'b1, 1'b0, 60);
        sv <= 1'b1;
        ticks(20);
        sv <= 1'b0;
        pulse_supply();
        ticks(60);
        check(save_q.size(), 0);
        do_reset(1'b1);
        note(1'b0);
        hold(1'b0, 1'b1, 60);
        save_q.push_back({27'h0, exp_pos});
        pulse_supply();
        ticks(4);
        check(save_q.size(), 0);
        report_and_stop();
    end

    initial begin
        #1000000;
        bad_count++;
        report_and_stop();
    end
endmodule : tap_counter_test

`default_nettype wire

/* hdl/input_debouncer.sv */
// one active-low input filter, stepped by the shared 1 ms tick
// assumes the raw input is already synchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "tap_counter_map.svh"

module input_debouncer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic raw_n,
    output logic clean_n
);
    tap_counter_pkg::db_regs_t s_reg;
    tap_counter_pkg::db_regs_t s_next;

    always_comb begin
        s_next = s_reg;
        if (raw_n == s_reg.stable) begin
            s_next.cnt = '0;
        end else if (tick) begin
            if (s_reg.cnt == `DB_W'(`DEBOUNCE_MS - 1)) begin
                s_next.stable = raw_n;
                s_next.cnt = '0;
            end else begin
                s_next.cnt = s_reg.cnt + `DB_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg.stable <= 1'b1;
            s_reg.cnt <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign clean_n = s_reg.stable;

    a_glitch_ignored: assert property (@(posedge clk) disable iff (rst)
        (raw_n == s_reg.stable) |=> $stable(clean_n))
        else $error("filtered level moved without a held change");

endmodule : input_debouncer
`default_nettype wire

/* hdl/tap_counter.sv */
// push-button tap counter: debounce, saturating position, scan rates, save/restore
// assumes synchronous inputs, a supply monitor level and an external nonvolatile word
`timescale 1ns/1ns
`default_nettype none
`include "tap_counter_map.svh"

module tap_counter #(
    parameter logic [`TICK_W-1:0] TICK_CYCLES = `TICK_W'(`TICK_CYCLES)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step_up_n,
    input wire logic step_down_n,
    input wire logic save_enable_n,
    input wire logic supply_low,
    input wire logic [`POS_W-1:0] nvm_rdata,
    output logic nvm_write,
    output logic [`POS_W-1:0] nvm_wdata,
    output logic [`POS_W-1:0] wiper_pos,
    output logic [`TAPS-1:0] tap_select
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [`POS_W-1:0] sat_step(input logic [`POS_W-1:0] p,
                                                   input logic up);
        if (up) begin
            sat_step = (p == `POS_TOP) ? p : p + `POS_W'(1);
        end else begin
            sat_step = (p == `POS_BOTTOM) ? p : p - `POS_W'(1);
        end
    endfunction : sat_step

    function automatic logic [`TAPS-1:0] tap_decode(input logic [`POS_W-1:0] p);
        tap_decode = `TAPS'(1) << p;
    endfunction : tap_decode

    tap_counter_pkg::pot_regs_t s_reg;
    tap_counter_pkg::pot_regs_t s_next;
    logic tick;
    logic up_db_n;
    logic dn_db_n;
    logic ase_db_n;
    logic up_only;
    logic dn_only;
    logic step_now;
    logic [`RATE_W-1:0] period;

    // ------------------------------------------------------------
    // filters
    // ------------------------------------------------------------
    assign tick = (s_reg.pre == TICK_CYCLES - `TICK_W'(1));

    input_debouncer u_up (.clk(clk), .rst(rst), .tick(tick),
        .raw_n(step_up_n), .clean_n(up_db_n));
    input_debouncer u_dn (.clk(clk), .rst(rst), .tick(tick),
        .raw_n(step_down_n), .clean_n(dn_db_n));
    input_debouncer u_ase (.clk(clk), .rst(rst), .tick(tick),
        .raw_n(save_enable_n), .clean_n(ase_db_n));

    assign up_only = !up_db_n && dn_db_n;
    assign dn_only = !dn_db_n && up_db_n;
    assign period = s_reg.fast ? `RATE_W'(`FAST_MS) : `RATE_W'(`SLOW_MS);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        step_now = 1'b0;
        s_next.save = 1'b0;
        s_next.pre = tick ? '0 : s_reg.pre + `TICK_W'(1);
        s_next.ase_prev = ase_db_n;
        s_next.supply_prev = supply_low;
        unique case (s_reg.state)
            tap_counter_pkg::ST_LOAD: begin
                // raw pin is caught here, the filter has not settled yet
                s_next.pos = nvm_rdata;
                s_next.ase_at_pu = save_enable_n;
                s_next.state = tap_counter_pkg::ST_IDLE;
            end
            tap_counter_pkg::ST_IDLE: begin
                if (!s_reg.lock && (up_only || dn_only)) begin
                    step_now = 1'b1;
                    s_next.dir_up = up_only;
                    s_next.rate_cnt = '0;
                    s_next.hold_cnt = '0;
                    s_next.fast = 1'b0;
                    s_next.state = tap_counter_pkg::ST_SCAN;
                end
            end
            tap_counter_pkg::ST_SCAN: begin
                if (up_db_n && dn_db_n) begin
                    s_next.state = tap_counter_pkg::ST_IDLE;
                    s_next.fast = 1'b0;
                    s_next.rate_cnt = '0;
                    s_next.hold_cnt = '0;
                end else if (!s_reg.lock && (up_only || dn_only) && tick) begin
                    s_next.dir_up = up_only;
                    if (s_reg.hold_cnt == `HOLD_W'(`HOLD_MS - 1)) begin
                        s_next.fast = 1'b1;
                    end else begin
                        s_next.hold_cnt = s_reg.hold_cnt + `HOLD_W'(1);
                    end
                    if (s_reg.rate_cnt + `RATE_W'(1) >= period) begin
                        step_now = 1'b1;
                        s_next.rate_cnt = '0;
                    end else begin
                        s_next.rate_cnt = s_reg.rate_cnt + `RATE_W'(1);
                    end
                end
            end
        endcase
        if (step_now) begin
            s_next.pos = sat_step(s_reg.pos, up_only);
        end
        s_next.tap = tap_decode(s_next.pos);
        if (s_reg.state != tap_counter_pkg::ST_LOAD) begin
            if (s_reg.ase_at_pu && !ase_db_n) begin
                s_next.lock = 1'b1;
            end else if (ase_db_n) begin
                s_next.lock = 1'b0;
            end
            if (!ase_db_n && supply_low && !s_reg.supply_prev) begin
                s_next.save = 1'b1;
            end
            if (ase_db_n && !s_reg.ase_prev) begin
                s_next.save = 1'b1;
            end
            if (s_next.save) begin
                s_next.save_data = s_reg.pos;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.state <= tap_counter_pkg::ST_LOAD;
            s_reg.pos <= `POS_RESET;
            s_reg.tap <= `TAPS'(1);
            s_reg.ase_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign nvm_write = s_reg.save;
    assign nvm_wdata = s_reg.save_data;
    assign wiper_pos = s_reg.pos;
    assign tap_select = s_reg.tap;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_load_first: assert property (@(posedge clk) disable iff (rst)
        // rst is still sampled high at the releasing edge, so gate on it here
        (!rst && s_reg.state == tap_counter_pkg::ST_LOAD) |=>
        (wiper_pos == $past(nvm_rdata)) && (s_reg.state == tap_counter_pkg::ST_IDLE))
        else $error("power-up load missed");
    a_tap_onehot: assert property (@(posedge clk) disable iff (rst)
        $onehot(tap_select) && (tap_select == tap_decode(wiper_pos)))
        else $error("tap select not one-hot on position");
    a_up_step: assert property (@(posedge clk) disable iff (rst)
        (step_now && up_only && wiper_pos != `POS_TOP) |=>
        (wiper_pos == $past(wiper_pos) + `POS_W'(1)))
        else $error("up step not by one");
    a_down_step: assert property (@(posedge clk) disable iff (rst)
        (step_now && dn_only && wiper_pos != `POS_BOTTOM) |=>
        (wiper_pos == $past(wiper_pos) - `POS_W'(1)))
        else $error("down step not by one");
    a_no_wrap: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state != tap_counter_pkg::ST_LOAD &&
         ((wiper_pos == `POS_TOP && !dn_only) || (wiper_pos == `POS_BOTTOM && !up_only)))
        |=> $stable(wiper_pos))
        else $error("position wrapped");
    a_both_hold: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state != tap_counter_pkg::ST_LOAD && !up_db_n && !dn_db_n)
        |=> $stable(wiper_pos))
        else $error("step with both inputs low");
    a_lock_hold: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state != tap_counter_pkg::ST_LOAD && s_reg.lock) |=> $stable(wiper_pos))
        else $error("step while locked out");
    a_release_idle: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state == tap_counter_pkg::ST_SCAN && up_db_n && dn_db_n) |=>
        (s_reg.state == tap_counter_pkg::ST_IDLE) && !s_reg.fast && $stable(wiper_pos))
        else $error("release did not end scan");
    a_manual_save: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state != tap_counter_pkg::ST_LOAD && ase_db_n && !s_reg.ase_prev) |=>
        nvm_write && (nvm_wdata == $past(wiper_pos)) ##1 !nvm_write)
        else $error("manual save missing");
    a_auto_save: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state != tap_counter_pkg::ST_LOAD && !ase_db_n && supply_low &&
         !s_reg.supply_prev) |=> nvm_write && (nvm_wdata == $past(wiper_pos)))
        else $error("power-loss save missing");
    a_slow_gap: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state == tap_counter_pkg::ST_SCAN && !s_reg.fast) |->
        (s_reg.rate_cnt < `RATE_W'(`SLOW_MS)))
        else $error("slow rate counter overran");
    a_slow_step: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state == tap_counter_pkg::ST_SCAN && !s_reg.fast && step_now) |->
        tick && (s_reg.rate_cnt == `RATE_W'(`SLOW_MS - 1)))
        else $error("slow step off its period");
    a_fast_gap: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state == tap_counter_pkg::ST_SCAN && s_reg.fast && step_now) |->
        tick && (s_reg.rate_cnt == `RATE_W'(`FAST_MS - 1)))
        else $error("fast step off its period");
    a_hold_switch: assert property (@(posedge clk) disable iff (rst)
        (s_reg.state == tap_counter_pkg::ST_SCAN && !s_reg.fast && s_next.fast) |->
        tick && (s_reg.hold_cnt == `HOLD_W'(`HOLD_MS - 1)))
        else $error("fast scan entered at the wrong time");

endmodule : tap_counter
`default_nettype wire

/* hdl/tap_counter_map.svh */
// constants for the push-button tap counter: timing, widths, reset values
// assumes a 50 MHz core clock; all slow timing runs on a 1 ms tick
`ifndef TAP_COUNTER_MAP_SVH
`define TAP_COUNTER_MAP_SVH

`define CLK_PERIOD_NS 20
`define TICK_NS 1000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_W 16

`define DEBOUNCE_MS 40
`define SLOW_MS 250
`define FAST_MS 50
`define HOLD_MS 1000

`define DB_W 6
`define RATE_W 8
`define HOLD_W 10
`define POS_W 5
`define TAPS 32
`define POS_TOP 5'h1f
`define POS_BOTTOM 5'h00
`define POS_RESET 5'h00

`endif

/* hdl/tap_counter_pkg.sv */
// types for the push-button tap counter
// assumes tap_counter_map.svh on the include path
`include "tap_counter_map.svh"

package tap_counter_pkg;

    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SCAN} pot_state_t;

    typedef struct packed {
        logic stable;
        logic [`DB_W-1:0] cnt;
    } db_regs_t;

    typedef struct packed {
        pot_state_t state;
        logic [`POS_W-1:0] pos;
        logic [`TAPS-1:0] tap;
        logic [`RATE_W-1:0] rate_cnt;
        logic [`HOLD_W-1:0] hold_cnt;
        logic fast;
        logic dir_up;
        logic ase_prev;
        logic supply_prev;
        logic ase_at_pu;
        logic lock;
        logic save;
        logic [`POS_W-1:0] save_data;
        logic [`TICK_W-1:0] pre;
    } pot_regs_t;

endpackage : tap_counter_pkg
